// ==== design/pit_target.sv ====
// Operation
// (R01) answer 7-bit addresses only, ignore others
// (R02) own address 10010 plus factory low bits
// (R03) start is data fall while clock high
// (R04) seven address bits, then direction, compare
// (R05) change data only while clock low
// (R06) acknowledge matching address on ninth clock
// (R07) direction 0 writes, direction 1 reads
// (R08) eight data bits then receiver acknowledge
// (R09) stop is data rise while clock high
// (R10) unimplemented register reads return ff
// (R11) master code 00001xxx enters high speed
// (R12) repeated start follows master code
// (R13) stop leaves high speed mode
// (R14) repeated start keeps high speed mode
// (R15) same protocol at all supported rates
// (R16) undervoltage lockout holds registers at default
// (R17) oscillator enabled on bus access
// (R18) controller makes clock, device never drives it
// (R19) bus released while idle
// (R20) repeated start detected like start
// (R21) first write byte selects register pointer
// (R22) read uses pointer, ends on nack
`timescale 1ns/1ps
`default_nettype none
`include "pit_consts.svh"

module pit_target (
  input  wire logic               clk_sys_i,
  input  wire logic               reset_n_i,
  input  wire logic               uvlo_i,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_n_o,
  output logic                    hs_mode_o,
  output logic                    osc_en_o,
  output logic                    regs_clear_o,
  output logic                    wr_valid_o,
  input  wire logic               wr_ready_i,
  output pit_pkg::pit_byte_t      wr_reg_o,
  output pit_pkg::pit_byte_t      wr_data_o,
  output pit_pkg::pit_byte_t      rd_addr_o,
  input  wire pit_pkg::pit_byte_t rd_data_i,
  input  wire logic               rd_hit_i,
  output logic                    rd_strobe_o,
  output logic                    overflow_o
);
  import pit_pkg::*;

  // synchronisers: the first stage feeds only the second
  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;
  logic uvlo_m_q;
  logic uvlo_s_q;
  logic rst;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      uvlo_m_q <= 1'b1;
      uvlo_s_q <= 1'b1;
    end else begin
      uvlo_m_q <= uvlo_i;
      uvlo_s_q <= uvlo_m_q;
    end
  end

  // lockout acts as a reset so every register except the queue memory sits at its default
  assign rst          = !reset_n_i || uvlo_s_q; // [R16]
  assign regs_clear_o = rst; // [R16]

  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_s_q && !scl_p_q;
  assign scl_fall  = !scl_s_q && scl_p_q;
  // a repeated start looks exactly like a start
  assign start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q; // [R03] [R20]
  assign stop_det  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q; // [R09]

  pit_state_e state_q;
  pit_state_e state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  pit_byte_t  sh_q;
  pit_byte_t  sh_d;
  pit_byte_t  tx_q;
  pit_byte_t  tx_d;
  pit_byte_t  ptr_q;
  pit_byte_t  ptr_d;
  logic       drv_q;
  logic       drv_d;
  logic       rd_q;
  logic       rd_d;
  logic       first_q;
  logic       first_d;
  logic       hs_q;
  logic       hs_d;
  logic       osc_q;
  logic       osc_d;
  logic       rdstb_q;
  logic       rdstb_d;
  logic       ovf_q;
  logic       ovf_d;
  pit_byte_t  rd_byte;
  logic       addr_match;
  logic       mcode;
  logic       foreign;

  // write bytes queue here so a slow consumer can refuse with a nack
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic [15:0] fifo_out;

  pit_fifo #(
    .WIDTH (`PIT_FIFO_WIDTH),
    .DEPTH (`PIT_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({ptr_q, sh_q}),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (fifo_out)
  );

  assign wr_reg_o  = fifo_out[15:8];
  assign wr_data_o = fifo_out[7:0];

  assign rd_byte = rd_hit_i ? rd_data_i : `PIT_NO_REG_BYTE; // [R10]
  assign addr_match = (sh_q[7:1] == {`PIT_ADDR_HI, `PIT_ADDR_LSB}); // [R02] [R04]
  assign mcode   = (sh_q[7:3] == `PIT_MCODE_HI); // [R11]
  // general call and ten-bit headers never match; kept explicit
  assign foreign = (sh_q[7:1] == `PIT_GCALL_ADDR) ||
                   (sh_q[7:3] == `PIT_TEN_BIT_HI); // [R01]

  assign fifo_in_valid = (state_q == PIT_ST_WDATA) && scl_fall &&
                         (cnt_q == `PIT_BITS) && !first_q && !start_det &&
                         !stop_det;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    tx_d    = tx_q;
    ptr_d   = ptr_q;
    drv_d   = drv_q;
    rd_d    = rd_q;
    first_d = first_q;
    hs_d    = hs_q;
    osc_d   = osc_q;
    rdstb_d = 1'b0;
    ovf_d   = 1'b0;
    if (start_det) begin
      state_d = PIT_ST_ADDR; // [R03] [R20]
      cnt_d   = `PIT_CNT_ZERO;
      drv_d   = 1'b0;
      osc_d   = 1'b1; // [R17]
      // high-speed settings survive a repeated start
      hs_d    = hs_q; // [R14]
    end else if (stop_det) begin
      state_d = PIT_ST_IDLE; // [R09] [R19]
      drv_d   = 1'b0;
      hs_d    = 1'b0; // [R13]
      osc_d   = 1'b0;
    end else begin
      unique case (state_q)
        PIT_ST_IDLE: begin
          drv_d = 1'b0; // [R19]
        end
        PIT_ST_ADDR, PIT_ST_WDATA: begin
          // sample on the rising clock, data is stable while high
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s_q}; // [R05] [R08]
            cnt_d = cnt_q + `PIT_CNT_ONE;
          end else if (scl_fall && cnt_q == `PIT_BITS) begin
            cnt_d = `PIT_CNT_ZERO;
            if (state_q == PIT_ST_ADDR) begin
              if (!hs_q && mcode) begin
                // master code is never acknowledged
                hs_d    = 1'b1; // [R11] [R12]
                state_d = PIT_ST_IGNORE;
              end else if (addr_match && !foreign) begin
                drv_d   = 1'b1; // [R06]
                rd_d    = sh_q[0]; // [R07]
                first_d = !sh_q[0];
                state_d = PIT_ST_ACK;
              end else begin
                state_d = PIT_ST_IGNORE; // [R01]
              end
            end else if (first_q) begin
              ptr_d   = sh_q; // [R21]
              first_d = 1'b0;
              drv_d   = 1'b1; // [R08]
              state_d = PIT_ST_ACK;
            end else if (fifo_in_ready) begin
              drv_d   = 1'b1; // [R08] [R21]
              state_d = PIT_ST_ACK;
            end else begin
              ovf_d   = 1'b1;
              state_d = PIT_ST_IGNORE;
            end
          end
        end
        PIT_ST_ACK: begin
          // acknowledge is held through the whole ninth high phase
          if (scl_fall) begin
            cnt_d = `PIT_CNT_ZERO;
            if (rd_q) begin
              tx_d    = rd_byte; // [R10] [R22]
              drv_d   = !rd_byte[7]; // [R05]
              rdstb_d = 1'b1;
              state_d = PIT_ST_TX;
            end else begin
              drv_d   = 1'b0;
              state_d = PIT_ST_WDATA;
            end
          end
        end
        PIT_ST_TX: begin
          if (scl_rise) begin
            cnt_d = cnt_q + `PIT_CNT_ONE;
          end else if (scl_fall) begin
            if (cnt_q == `PIT_BITS) begin
              drv_d   = 1'b0; // [R08]
              state_d = PIT_ST_RACK;
            end else begin
              tx_d  = {tx_q[6:0], 1'b0};
              drv_d = !tx_q[6]; // [R05]
            end
          end
        end
        PIT_ST_RACK: begin
          if (scl_rise) begin
            if (sda_s_q) begin
              state_d = PIT_ST_IGNORE; // [R22]
            end else begin
              state_d = PIT_ST_ACK;
            end
          end
        end
        PIT_ST_IGNORE: begin
          drv_d = 1'b0;
        end
        default: begin
          state_d = PIT_ST_IDLE;
          drv_d   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      state_q <= PIT_ST_IDLE;
      cnt_q   <= `PIT_CNT_ZERO;
      sh_q    <= '0;
      tx_q    <= '0;
      ptr_q   <= '0;
      drv_q   <= 1'b0;
      rd_q    <= 1'b0;
      first_q <= 1'b0;
      hs_q    <= 1'b0;
      osc_q   <= 1'b0;
      rdstb_q <= 1'b0;
      ovf_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      tx_q    <= tx_d;
      ptr_q   <= ptr_d;
      drv_q   <= drv_d;
      rd_q    <= rd_d;
      first_q <= first_d;
      hs_q    <= hs_d;
      osc_q   <= osc_d;
      rdstb_q <= rdstb_d;
      ovf_q   <= ovf_d;
    end
  end

  // open drain: only ever pulls low, the clock pin is input only
  assign sda_o       = 1'b0; // [R18]
  assign sda_oe_n_o  = !drv_q; // [R19]
  assign hs_mode_o   = hs_q; // [R15]
  assign osc_en_o    = osc_q; // [R17]
  assign rd_addr_o   = ptr_q; // [R22]
  assign rd_strobe_o = rdstb_q;
  assign overflow_o  = ovf_q;

endmodule

`default_nettype wire

// ==== design/pit_consts.svh ====
`ifndef PIT_CONSTS_SVH
`define PIT_CONSTS_SVH

// upper five address bits are fixed, the two low ones are a factory constant
`define PIT_ADDR_HI     5'h12
`define PIT_ADDR_LSB    2'h0
// leading five bits of a high-speed master code byte
`define PIT_MCODE_HI    5'h01
`define PIT_GCALL_ADDR  7'h00
`define PIT_TEN_BIT_HI  5'h1e
`define PIT_NO_REG_BYTE 8'hff
`define PIT_BITS        4'h8
`define PIT_CNT_ZERO    4'h0
`define PIT_CNT_ONE     4'h1
`define PIT_FIFO_DEPTH  8
`define PIT_FIFO_WIDTH  16

`endif

// ==== design/pit_pkg.sv ====
package pit_pkg;

  typedef enum logic [2:0] {
    PIT_ST_IDLE   = 3'b000,
    PIT_ST_ADDR   = 3'b001,
    PIT_ST_ACK    = 3'b010,
    PIT_ST_WDATA  = 3'b011,
    PIT_ST_TX     = 3'b100,
    PIT_ST_RACK   = 3'b101,
    PIT_ST_IGNORE = 3'b110
  } pit_state_e;

  typedef logic [7:0] pit_byte_t;

endpackage

// ==== design/pit_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module pit_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    wp_d;
  logic [AW-1:0]    rp_q;
  logic [AW-1:0]    rp_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
    end
    if (pop) begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

endmodule

`default_nettype wire

// ==== test/pit_ctl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pit_ctl_model (
  input  wire logic clk_sys_i,
  input  wire logic sda_bus_i,
  output var logic  scl_o,
  output var logic  sda_o
);
  // scl stands high between frames, sda 1 means released to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // fin 0 gives a start or repeated start, fin 1 a stop
  task automatic cond(input logic fin);
    wt(5);
    sda_o <= ~fin;
    wt(5);
    scl_o <= 1'b1;
    wt(10);
    sda_o <= fin;
    wt(10);
    if (!fin) scl_o <= 1'b0;
  endtask
  // data moves mid-low, so the synced pins never see it near an scl edge
  task automatic bit_io(input logic b, output logic r);
    wt(5);
    sda_o <= b;
    wt(5);
    scl_o <= 1'b1;
    wt(10);
    r = sda_bus_i;
    scl_o <= 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule
`default_nettype wire

// ==== test/pit_target_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module pit_target_monitor (
  input wire logic               clk_sys_i,
  input wire logic               reset_n_i,
  input wire logic               uvlo_i,
  input wire logic               scl_i,
  input wire logic               sda_i,
  input wire logic               sda_o,
  input wire logic               sda_oe_n_o,
  input wire logic               hs_mode_o,
  input wire logic               osc_en_o,
  input wire logic               regs_clear_o,
  input wire logic               wr_valid_o,
  input wire logic               wr_ready_i,
  input wire pit_pkg::pit_byte_t wr_reg_o,
  input wire pit_pkg::pit_byte_t wr_data_o,
  input wire pit_pkg::pit_byte_t rd_addr_o,
  input wire pit_pkg::pit_byte_t rd_data_i,
  input wire logic               rd_hit_i,
  input wire logic               rd_strobe_o,
  input wire logic               overflow_o
);
  import pit_pkg::*;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  property p_uvlo_clear;
    uvlo_i [*4] |-> regs_clear_o && sda_oe_n_o && !hs_mode_o && !wr_valid_o;
  endproperty
  a_uvlo_clear: assert property (p_uvlo_clear)
    else $error("lockout left state set");
  property p_idle_release;
    !osc_en_o |-> sda_oe_n_o;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("sda pulled while idle");
  property p_change_low;
    $changed(sda_oe_n_o) |-> !scl_i;
  endproperty
  a_change_low: assert property (p_change_low)
    else $error("sda moved while scl high");
  property p_ack_len;
    $fell(sda_oe_n_o) |=> !sda_oe_n_o [*8];
  endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("low drive too short");
  property p_hs_exit;
    hs_mode_o && scl_i && $rose(sda_i) |-> ##[1:6] !hs_mode_o;
  endproperty
  a_hs_exit: assert property (p_hs_exit)
    else $error("high speed kept after stop");
  property p_hs_keep;
    hs_mode_o && scl_i && $fell(sda_i) |=> hs_mode_o [*8];
  endproperty
  a_hs_keep: assert property (p_hs_keep)
    else $error("high speed lost at restart");
  property p_osc_wake;
    scl_i && $fell(sda_i) |-> ##[1:6] osc_en_o;
  endproperty
  a_osc_wake: assert property (p_osc_wake)
    else $error("oscillator not woken");
  property p_fifo_hold;
    wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable({wr_reg_o, wr_data_o});
  endproperty
  a_fifo_hold: assert property (p_fifo_hold)
    else $error("queued write changed");
  c_hs: cover property (hs_mode_o);
  c_rd: cover property (rd_strobe_o);
  c_ovf: cover property (overflow_o);
endmodule
bind pit_target pit_target_monitor i_mon (
  .clk_sys_i    (clk_sys_i),
  .reset_n_i    (reset_n_i),
  .uvlo_i       (uvlo_i),
  .scl_i        (scl_i),
  .sda_i        (sda_i),
  .sda_o        (sda_o),
  .sda_oe_n_o   (sda_oe_n_o),
  .hs_mode_o    (hs_mode_o),
  .osc_en_o     (osc_en_o),
  .regs_clear_o (regs_clear_o),
  .wr_valid_o   (wr_valid_o),
  .wr_ready_i   (wr_ready_i),
  .wr_reg_o     (wr_reg_o),
  .wr_data_o    (wr_data_o),
  .rd_addr_o    (rd_addr_o),
  .rd_data_i    (rd_data_i),
  .rd_hit_i     (rd_hit_i),
  .rd_strobe_o  (rd_strobe_o),
  .overflow_o   (overflow_o)
);
`default_nettype wire

// ==== test/pmu_i2c_target_interface_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmu_i2c_target_interface_tb_top;
  import pit_pkg::*;
  logic        clk, reset_n, uvlo, wr_ready, rd_hit, scl, sda_m, ack, ovf_seen;
  logic        sda_o, sda_oe_n, hs, osc, clr, wr_valid, rd_stb, ovf;
  pit_byte_t   rd_data, wr_reg, wr_data, rd_addr, d;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          stb_n = 0;
  wire logic   sda = sda_m & sda_oe_n;
  // refused flag, address byte, pointer, data
  logic [24:0] rows [5] = '{25'h0_90_10_3c, 25'h1_92_00_00, 25'h1_00_00_00,
                            25'h1_f0_00_00, 25'h0_90_ff_00};
  pit_target i_dut (
    .clk_sys_i   (clk),
    .reset_n_i   (reset_n),
    .uvlo_i      (uvlo),
    .scl_i       (scl),
    .sda_i       (sda),
    .sda_o       (sda_o),
    .sda_oe_n_o  (sda_oe_n),
    .hs_mode_o   (hs),
    .osc_en_o    (osc),
    .regs_clear_o(clr),
    .wr_valid_o  (wr_valid),
    .wr_ready_i  (wr_ready),
    .wr_reg_o    (wr_reg),
    .wr_data_o   (wr_data),
    .rd_addr_o   (rd_addr),
    .rd_data_i   (rd_data),
    .rd_hit_i    (rd_hit),
    .rd_strobe_o (rd_stb),
    .overflow_o  (ovf)
  );
  pit_ctl_model i_ctl (
    .clk_sys_i(clk),
    .sda_bus_i(sda),
    .scl_o    (scl),
    .sda_o    (sda_m)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic pop(input logic [15:0] exp);
    int n = 0;
    @(negedge clk);
    while (wr_valid !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk({wr_reg, wr_data}, exp);
    @(posedge clk);
    wr_ready <= 1'b1;
    @(posedge clk);
    wr_ready <= 1'b0;
    @(posedge clk);
  endtask
  // pointer write, repeated start, two reads: acked then refused
  task automatic rd_seq(input pit_byte_t ptr, input pit_byte_t exp);
    i_ctl.cond(0);
    i_ctl.wr_byte(8'h90, ack);
    i_ctl.wr_byte(ptr, ack);
    i_ctl.cond(0);
    i_ctl.wr_byte(8'h91, ack);
    chk(ack, 1'b0);
    i_ctl.rd_byte(1'b0, d);
    chk(d, exp);
    i_ctl.rd_byte(1'b1, d);
    chk(d, exp);
    i_ctl.cond(1);
    chk(rd_addr, ptr);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // far-side register file: implemented below 40h, value follows the pointer
  always @(posedge clk) begin
    ovf_seen <= (ovf_seen === 1'b1) || (ovf === 1'b1);
    stb_n    <= stb_n + ((rd_stb === 1'b1) ? 1 : 0);
    rd_hit   <= (rd_addr < 8'h40);
    rd_data  <= rd_addr ^ 8'h5f;
  end
  // whole run needs about 7100 clocks
  initial begin
    #400us;
    bad_count++;
    final_report();
  end
  initial begin
    reset_n = 1'b0;
    uvlo = 1'b0;
    wr_ready = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({clr, sda_oe_n, sda_o}, 16'h6);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    $display("reset done");
    foreach (rows[k]) begin
      i_ctl.cond(0);
      i_ctl.wr_byte(rows[k][23:16], ack);
      chk(ack, rows[k][24]);
      if (!rows[k][24]) begin
        i_ctl.wr_byte(rows[k][15:8], ack);
        i_ctl.wr_byte(rows[k][7:0], ack);
        chk(ack, 1'b0);
      end
      i_ctl.cond(1);
      if (!rows[k][24]) pop(rows[k][15:0]);
      repeat (6) @(negedge clk);
      chk({osc, wr_valid}, 16'h0);
      @(posedge clk);
      $display("row %0d done", k);
    end
    rd_seq(8'h77, 8'hff);
    rd_seq(8'h05, 8'h5a);
    chk(16'(stb_n), 16'h4);
    $display("reads done");
    i_ctl.cond(0);
    i_ctl.wr_byte(8'h0b, ack);
    chk({ack, hs, osc}, 16'h7);
    i_ctl.cond(0);
    i_ctl.wr_byte(8'h90, ack);
    i_ctl.wr_byte(8'h21, ack);
    i_ctl.wr_byte(8'hc3, ack);
    chk(ack, 1'b0);
    i_ctl.cond(0);
    i_ctl.wr_byte(8'h92, ack);
    chk({ack, hs}, 16'h3);
    i_ctl.cond(1);
    repeat (8) @(negedge clk);
    chk(hs, 1'b0);
    pop(16'h21c3);
    $display("high speed done");
    i_ctl.cond(0);
    i_ctl.wr_byte(8'h90, ack);
    i_ctl.wr_byte(8'h40, ack);
    for (int j = 0; j < 9; j++) begin
      i_ctl.wr_byte(8'h80 + 8'(j), ack);
      chk(ack, j == 8);
    end
    i_ctl.cond(1);
    chk(ovf_seen, 1'b1);
    for (int j = 0; j < 8; j++) pop({8'h40, 8'h80 + 8'(j)});
    chk(wr_valid, 1'b0);
    $display("overflow done");
    uvlo <= 1'b1;
    repeat (4) @(negedge clk);
    chk({clr, hs, osc, wr_valid}, 16'h8);
    @(posedge clk);
    uvlo <= 1'b0;
    repeat (6) @(posedge clk);
    $display("lockout done");
    final_report();
  end
endmodule
`default_nettype wire
